// >>> hdl/ssi_device.sv
// Purpose: Slave end of the two-wire register access port
// Assumes: Serial clock and data arrive asynchronously to sys_clk
// Notes:   Register file lives outside; pointer, strobes, data here
// Behaviour
// - Master clocks and starts; slave only follows
// - One data bit per serial clock
// - Nine-clock frame: eight bits then acknowledge
// - Bytes and acknowledges follow without gaps
// - Data changes only while clock low
// - Slave never makes start or stop
// - Long clock low resets machine, releases data
// - Reads answered anytime with latest result
// - Ready within 500 ms of reset
// - First write byte loads persistent pointer
// - Without repeated start, bytes are write data
// - Invalid pointer abandons the operation
// - Address latched from straps on first match of the upper five address bits
module ssi_device #(
  parameter int TIMEOUT_CYC = ssi_pkg::TIMEOUT_CYC,
  parameter int READY_CYC   = ssi_pkg::POR_READY_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Serial link
  ssi_link_if.dev         link,
  // Address straps
  input  wire logic       addrStrapEnable,
  input  wire logic       addrSelect,
  // Register side
  output logic      [7:0] regPtr,
  input  wire logic       regValid,
  output logic            wrStrobe,
  output logic      [7:0] wrData,
  input  wire logic [7:0] rdData,
  // Status
  output logic            busReady,
  output logic            addrLocked,
  output logic      [6:0] busAddr
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int RW = $clog2(READY_CYC + 1);

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_ADDR = 5'h02,
    D_PTR  = 5'h04,
    D_WR   = 5'h08,
    D_RD   = 5'h10
  } ssi_dstate_e;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] enSync;
  logic [1:0] selSync;
  logic       sclPrev;
  logic       sdaPrev;
  logic       sclS;
  logic       sdaS;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      enSync  <= 2'h3;
      selSync <= 2'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], link.sclLevel};
      sdaSync <= {sdaSync[0], link.sdaLevel};
      enSync  <= {enSync[0], addrStrapEnable};
      selSync <= {selSync[0], addrSelect};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  assign sclS = sclSync[1];
  assign sdaS = sdaSync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Serial state machine
  ssi_dstate_e state;
  ssi_dstate_e next_state;
  ssi_dstate_e afterAck;
  ssi_dstate_e next_afterAck;
  logic [3:0]  bitCnt;
  logic [3:0]  next_bitCnt;
  logic [7:0]  shiftReg;
  logic [7:0]  next_shiftReg;
  logic        sdaOe;
  logic        next_sdaOe;
  logic        mAck;
  logic        next_mAck;
  logic [TW-1:0] lowCnt;
  logic [TW-1:0] next_lowCnt;
  logic [RW-1:0] readyCnt;
  logic [RW-1:0] next_readyCnt;
  logic        next_busReady;
  logic [7:0]  next_regPtr;
  logic        next_wrStrobe;
  logic [7:0]  next_wrData;
  logic        next_addrLocked;
  logic [6:0]  next_busAddr;

  logic       rise;
  logic       fall;
  logic       startCond;
  logic       stopCond;
  logic       timeout;
  logic [6:0] strapAddr;
  logic [6:0] candAddr;
  logic       upperHit;

  assign rise      = sclS && !sclPrev;
  assign fall      = !sclS && sclPrev;
  // Edges of data while clock high mark start and stop
  assign startCond = busReady && sclS && sclPrev && sdaPrev && !sdaS;
  assign stopCond  = sclS && sclPrev && !sdaPrev && sdaS;
  assign timeout   = !sclS && (lowCnt == TW'(TIMEOUT_CYC - 1));
  assign strapAddr = enSync[1] ? ssi_pkg::ADDR_DEFAULT
                   : (selSync[1] ? ssi_pkg::ADDR_SEL_HI
                                 : ssi_pkg::ADDR_SEL_LO);
  assign candAddr  = addrLocked ? busAddr : strapAddr;
  assign upperHit  = shiftReg[7:3] == ssi_pkg::ADDR_UPPER5;

  always_comb begin
    next_state      = state;
    next_afterAck   = afterAck;
    next_bitCnt     = bitCnt;
    next_shiftReg   = shiftReg;
    next_sdaOe      = sdaOe;
    next_mAck       = mAck;
    next_regPtr     = regPtr;
    next_wrStrobe   = 1'b0;
    next_wrData     = wrData;
    next_addrLocked = addrLocked;
    next_busAddr    = busAddr;
    next_readyCnt   = readyCnt;
    next_busReady   = busReady;
    // Power-on readiness count
    if (!busReady) begin
      next_readyCnt = readyCnt + RW'(1);
      next_busReady = readyCnt == RW'(READY_CYC - 1);
    end
    // Clock-low watchdog
    if (sclS) begin
      next_lowCnt = '0;
    end else if (!timeout) begin
      next_lowCnt = lowCnt + TW'(1);
    end else begin
      next_lowCnt = lowCnt;
    end
    if (timeout || stopCond) begin
      next_state  = D_IDLE;
      next_bitCnt = 4'h0;
      next_sdaOe  = 1'b0;
    end else if (startCond) begin
      next_state  = D_ADDR;
      next_bitCnt = 4'hf;  // Next fall opens the first bit
      next_sdaOe  = 1'b0;
    end else if (state != D_IDLE) begin
      if (rise) begin
        if (bitCnt < ssi_pkg::ACK_SLOT && state != D_RD) begin
          next_shiftReg = {shiftReg[6:0], sdaS};
        end else if (bitCnt == ssi_pkg::ACK_SLOT && state == D_RD) begin
          next_mAck = !sdaS;
        end
      end
      // All driven changes happen on the falling clock
      if (fall) begin
        if (bitCnt < ssi_pkg::LAST_DATA_BIT || bitCnt == 4'hf) begin
          next_bitCnt = bitCnt + 4'h1;
          if (state == D_RD) begin
            next_shiftReg = {shiftReg[6:0], 1'b1};
            next_sdaOe    = !shiftReg[6];
          end
        end else if (bitCnt == ssi_pkg::LAST_DATA_BIT) begin
          next_bitCnt = ssi_pkg::ACK_SLOT;
          next_sdaOe  = 1'b1;
          case (state)
            D_ADDR: begin
              if (upperHit && !addrLocked) begin
                next_addrLocked = 1'b1;
                next_busAddr    = strapAddr;
              end
              if (upperHit && shiftReg[7:1] == candAddr) begin
                next_afterAck = shiftReg[0] ? D_RD : D_PTR;
              end else begin
                next_sdaOe    = 1'b0;
                next_afterAck = D_IDLE;
              end
            end
            D_PTR: begin
              next_regPtr   = shiftReg;
              next_afterAck = D_WR;
            end
            D_WR: begin
              next_wrData   = shiftReg;
              next_wrStrobe = 1'b1;
              next_afterAck = D_WR;
            end
            default: begin
              next_sdaOe    = 1'b0;
              next_afterAck = D_RD;
            end
          endcase
        end else begin
          // Acknowledge slot over; next byte starts at once
          next_bitCnt = 4'h0;
          next_sdaOe  = 1'b0;
          next_state  = afterAck;
          if ((afterAck == D_WR || afterAck == D_RD) && !regValid) begin
            next_state = D_IDLE;
          end else if (state == D_RD && !mAck) begin
            next_state = D_IDLE;
          end else if (afterAck == D_RD) begin
            next_shiftReg = rdData;
            next_sdaOe    = !rdData[7];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= D_IDLE;
      afterAck   <= D_IDLE;
      bitCnt     <= 4'h0;
      shiftReg   <= 8'h00;
      sdaOe      <= 1'b0;
      mAck       <= 1'b0;
      lowCnt     <= '0;
      readyCnt   <= '0;
      busReady   <= 1'b0;
      regPtr     <= 8'h00;
      wrStrobe   <= 1'b0;
      wrData     <= 8'h00;
      addrLocked <= 1'b0;
      busAddr    <= ssi_pkg::ADDR_DEFAULT;
    end else begin
      state      <= next_state;
      afterAck   <= next_afterAck;
      bitCnt     <= next_bitCnt;
      shiftReg   <= next_shiftReg;
      sdaOe      <= next_sdaOe;
      mAck       <= next_mAck;
      lowCnt     <= next_lowCnt;
      readyCnt   <= next_readyCnt;
      busReady   <= next_busReady;
      regPtr     <= next_regPtr;
      wrStrobe   <= next_wrStrobe;
      wrData     <= next_wrData;
      addrLocked <= next_addrLocked;
      busAddr    <= next_busAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain data only; the clock is never driven
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe  = sdaOe;

endmodule

// >>> hdl/ssi_pkg.sv
// Purpose: Shared constants for the two-wire slave port and its host
// Assumes: sys_clk at 100 MHz
// Notes:   Long counts become top-level parameters for simulation
package ssi_pkg;

  localparam int SYS_CLK_MHZ = 100;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int TIMEOUT_MIN_MS  = 25;
  localparam int TIMEOUT_MAX_MS  = 35;
  localparam int TIMEOUT_CYC     = TIMEOUT_MIN_MS * SYS_CLK_MHZ * 1000;
  localparam int POR_READY_MS    = 500;
  localparam int POR_READY_CYC   = POR_READY_MS * SYS_CLK_MHZ * 1000;
  localparam int SCL_KHZ         = 100;
  localparam int QTR_CYC         = (SYS_CLK_MHZ * 1000) / (4 * SCL_KHZ);

  ////////////////////////////////////////////////////////////////////////////
  // Framing
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [1:0] LAST_PHASE    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Slave addresses
  localparam logic [4:0] ADDR_UPPER5  = 5'h0b;
  localparam logic [6:0] ADDR_DEFAULT = 7'h2e;
  localparam logic [6:0] ADDR_SEL_HI  = 7'h2d;
  localparam logic [6:0] ADDR_SEL_LO  = 7'h2c;

  ////////////////////////////////////////////////////////////////////////////
  // Host commands and sequence items
  typedef enum logic [1:0] {
    CMD_WRITE  = 2'h0,
    CMD_SETPTR = 2'h1,
    CMD_READ   = 2'h2,
    CMD_PREAD  = 2'h3
  } ssi_cmd_e;

  typedef enum logic [2:0] {
    IT_START = 3'h0,
    IT_ADDRW = 3'h1,
    IT_ADDRR = 3'h2,
    IT_PTR   = 3'h3,
    IT_DATA  = 3'h4,
    IT_RX    = 3'h5,
    IT_STOP  = 3'h6
  } ssi_item_e;

endpackage

// >>> hdl/ssi_link_if.sv
// Purpose: Open-drain two-wire link between host and slave port
// Assumes: Pull-ups on both wires
// Notes:   Wire levels are resolved here from the enables
interface ssi_link_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic sclLevel;
  logic sdaLevel;

  // Pulled high unless a driver pulls low
  assign sclLevel = hostSclOe ? hostSclOut : 1'b1;
  assign sdaLevel = (hostSdaOe ? hostSdaOut : 1'b1)
                  & (devSdaOe ? devSdaOut : 1'b1);

  modport dev (
    input  sclLevel,
    input  sdaLevel,
    output devSdaOut,
    output devSdaOe
  );

  modport host (
    input  sclLevel,
    input  sdaLevel,
    output hostSclOut,
    output hostSclOe,
    output hostSdaOut,
    output hostSdaOe
  );
endinterface

// >>> hdl/ssi_host.sv
// Purpose: Master end that clocks and sequences register transfers
// Assumes: Serial clock made here by dividing sys_clk
// Notes:   Each bit spans four quarter periods, clock high in last two
module ssi_host #(
  parameter int QTR_CYC = ssi_pkg::QTR_CYC
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Serial link
  ssi_link_if.host              link,
  // Command port
  input  wire logic             cmdValid,
  output logic                  cmdReady,
  input  wire ssi_pkg::ssi_cmd_e cmdKind,
  input  wire logic       [6:0] cmdAddr,
  input  wire logic       [7:0] cmdPtr,
  input  wire logic       [7:0] cmdData,
  // Results
  output logic                  done,
  output logic            [7:0] rdData,
  output logic                  ackErr
);

  localparam int QW = $clog2(QTR_CYC + 1);

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } ssi_hstate_e;

  // Item sequence for each command kind
  function automatic ssi_pkg::ssi_item_e itemAt(
    input ssi_pkg::ssi_cmd_e k,
    input logic [2:0]        s
  );
    itemAt = ssi_pkg::IT_STOP;
    case (k)
      ssi_pkg::CMD_WRITE: begin
        if (s == 3'h0) itemAt = ssi_pkg::IT_START;
        else if (s == 3'h1) itemAt = ssi_pkg::IT_ADDRW;
        else if (s == 3'h2) itemAt = ssi_pkg::IT_PTR;
        else if (s == 3'h3) itemAt = ssi_pkg::IT_DATA;
      end
      ssi_pkg::CMD_SETPTR: begin
        if (s == 3'h0) itemAt = ssi_pkg::IT_START;
        else if (s == 3'h1) itemAt = ssi_pkg::IT_ADDRW;
        else if (s == 3'h2) itemAt = ssi_pkg::IT_PTR;
      end
      ssi_pkg::CMD_READ: begin
        if (s == 3'h0) itemAt = ssi_pkg::IT_START;
        else if (s == 3'h1) itemAt = ssi_pkg::IT_ADDRR;
        else if (s == 3'h2) itemAt = ssi_pkg::IT_RX;
      end
      default: begin
        if (s == 3'h0 || s == 3'h3) itemAt = ssi_pkg::IT_START;
        else if (s == 3'h1) itemAt = ssi_pkg::IT_ADDRW;
        else if (s == 3'h2) itemAt = ssi_pkg::IT_PTR;
        else if (s == 3'h4) itemAt = ssi_pkg::IT_ADDRR;
        else if (s == 3'h5) itemAt = ssi_pkg::IT_RX;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data input synchroniser
  logic [1:0] sdaSync;
  logic       sdaS;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sdaSync <= 2'h3;
    end else begin
      sdaSync <= {sdaSync[0], link.sdaLevel};
    end
  end

  assign sdaS = sdaSync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  ssi_hstate_e       state;
  ssi_hstate_e       next_state;
  ssi_pkg::ssi_cmd_e kind;
  ssi_pkg::ssi_cmd_e next_kind;
  ssi_pkg::ssi_item_e item;
  logic [QW-1:0] qCnt;
  logic [QW-1:0] next_qCnt;
  logic [1:0]    phase;
  logic [1:0]    next_phase;
  logic [2:0]    step;
  logic [2:0]    next_step;
  logic [3:0]    bitIdx;
  logic [3:0]    next_bitIdx;
  logic [7:0]    shiftReg;
  logic [7:0]    next_shiftReg;
  logic          isRx;
  logic          next_isRx;
  logic [6:0]    addr;
  logic [6:0]    next_addr;
  logic [7:0]    ptr;
  logic [7:0]    next_ptr;
  logic [7:0]    data;
  logic [7:0]    next_data;
  logic          sclOe;
  logic          next_sclOe;
  logic          sdaOe;
  logic          next_sdaOe;
  logic          next_done;
  logic [7:0]    next_rdData;
  logic          next_ackErr;
  logic          tick;
  logic          endItem;

  assign cmdReady = state == H_IDLE;
  assign tick     = qCnt == QW'(QTR_CYC - 1);
  assign endItem  = tick && phase == ssi_pkg::LAST_PHASE;
  assign item     = itemAt(kind, step + 3'h1);

  always_comb begin
    next_state    = state;
    next_kind     = kind;
    next_qCnt     = '0;
    next_phase    = phase;
    next_step     = step;
    next_bitIdx   = bitIdx;
    next_shiftReg = shiftReg;
    next_isRx     = isRx;
    next_addr     = addr;
    next_ptr      = ptr;
    next_data     = data;
    next_done     = 1'b0;
    next_rdData   = rdData;
    next_ackErr   = ackErr;
    if (state == H_IDLE) begin
      next_phase = 2'h0;
      if (cmdValid) begin
        next_kind   = cmdKind;
        next_addr   = cmdAddr;
        next_ptr    = cmdPtr;
        next_data   = cmdData;
        next_step   = 3'h0;
        next_ackErr = 1'b0;
        next_state  = H_START;
      end
    end else begin
      next_qCnt = tick ? '0 : qCnt + QW'(1);
      if (tick) begin
        next_phase = phase + 2'h1;
      end
      if (endItem) begin
        if (state == H_STOP) begin
          next_done  = 1'b1;
          next_state = H_IDLE;
        end else if (state == H_BIT && bitIdx != ssi_pkg::ACK_SLOT) begin
          next_bitIdx   = bitIdx + 4'h1;
          next_shiftReg = {shiftReg[6:0], sdaS};
        end else if (state == H_BIT && !isRx && sdaS) begin
          next_ackErr = 1'b1;
          next_state  = H_STOP;
        end else begin
          if (state == H_BIT && isRx) begin
            next_rdData = shiftReg;
          end
          next_step   = step + 3'h1;
          next_bitIdx = 4'h0;
          next_isRx   = item == ssi_pkg::IT_RX;
          next_state  = H_BIT;
          case (item)
            ssi_pkg::IT_START: next_state    = H_START;
            ssi_pkg::IT_STOP:  next_state    = H_STOP;
            ssi_pkg::IT_ADDRW: next_shiftReg = {addr, 1'b0};
            ssi_pkg::IT_ADDRR: next_shiftReg = {addr, 1'b1};
            ssi_pkg::IT_PTR:   next_shiftReg = ptr;
            ssi_pkg::IT_DATA:  next_shiftReg = data;
            default:           next_shiftReg = 8'hff;
          endcase
        end
      end
    end
    // Pin levels; data held in the first quarter while clock falls
    next_sclOe = state != H_IDLE && phase < 2'h2;
    if (state == H_IDLE) begin
      next_sdaOe = 1'b0;
    end else if (phase == 2'h0) begin
      next_sdaOe = sdaOe;
    end else if (state == H_START) begin
      next_sdaOe = phase == ssi_pkg::LAST_PHASE;
    end else if (state == H_STOP) begin
      next_sdaOe = phase != ssi_pkg::LAST_PHASE;
    end else begin
      next_sdaOe = bitIdx != ssi_pkg::ACK_SLOT && !isRx && !shiftReg[7];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state    <= H_IDLE;
      kind     <= ssi_pkg::CMD_WRITE;
      qCnt     <= '0;
      phase    <= 2'h0;
      step     <= 3'h0;
      bitIdx   <= 4'h0;
      shiftReg <= 8'hff;
      isRx     <= 1'b0;
      addr     <= 7'h00;
      ptr      <= 8'h00;
      data     <= 8'h00;
      sclOe    <= 1'b0;
      sdaOe    <= 1'b0;
      done     <= 1'b0;
      rdData   <= 8'h00;
      ackErr   <= 1'b0;
    end else begin
      state    <= next_state;
      kind     <= next_kind;
      qCnt     <= next_qCnt;
      phase    <= next_phase;
      step     <= next_step;
      bitIdx   <= next_bitIdx;
      shiftReg <= next_shiftReg;
      isRx     <= next_isRx;
      addr     <= next_addr;
      ptr      <= next_ptr;
      data     <= next_data;
      sclOe    <= next_sclOe;
      sdaOe    <= next_sdaOe;
      done     <= next_done;
      rdData   <= next_rdData;
      ackErr   <= next_ackErr;
    end
  end

  assign link.hostSclOut = 1'b0;
  assign link.hostSclOe  = sclOe;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe  = sdaOe;

endmodule

// >>> tb/ssi_link_chk.sv
// Purpose: Protocol checks on the two-wire link
// Assumes: Host quarter period of 8 sys_clk cycles
// Notes:   Sees only the link signals
module ssi_link_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic sclLevel,
  input wire logic sdaLevel
);
  logic       sclQ;
  logic       sdaQ;
  logic [5:0] cnt;
  logic [5:0] next_cnt;

  // Clock rises since the last start
  always_comb begin
    next_cnt = cnt;
    if (sclQ && sclLevel && sdaQ && !sdaLevel) begin
      next_cnt = 6'h00;
    end else if (sclLevel && !sclQ) begin
      next_cnt = cnt + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      cnt  <= 6'h00;
    end else begin
      sclQ <= sclLevel;
      sdaQ <= sdaLevel;
      cnt  <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence sHighHeld;
    sclLevel && $past(sclLevel);
  endsequence

  sequence sStop;
    sclLevel && sclQ && $rose(sdaLevel);
  endsequence

  AST_DEV_NO_START:
    assert property (sHighHeld |-> !$rose(devSdaOe))
      else $error("slave pulled data while clock high");
  AST_DEV_NO_STOP:
    assert property (sHighHeld |-> !$fell(devSdaOe))
      else $error("slave released data while clock high");
  AST_DEV_DRIVE_LOW:
    assert property ($rose(devSdaOe) |-> !sclLevel && !$past(sclLevel))
      else $error("slave drive not inside clock low");
  AST_DEV_HOLD:
    assert property ($rose(sclLevel) |=> $stable(devSdaOe) [*4])
      else $error("slave bit moved in clock high");
  AST_HOST_CLK:
    assert property ($fell(sclLevel) |-> $rose(hostSclOe))
      else $error("clock fell without host");
  AST_NO_GAP:
    assert property ($fell(sclLevel) |-> ##[1:40] sclLevel)
      else $error("clock low gap too long");
  AST_NINE_ACK:
    assert property ($rose(sclLevel) && cnt % 6'h09 == 6'h08
                     |-> !hostSdaOe)
      else $error("host held data in acknowledge slot");
  AST_STOP_IDLE:
    assert property (sStop |=> !devSdaOe [*4])
      else $error("slave drove after stop");
endmodule

// >>> tb/tb.sv
// Purpose: Register transfers from host to slave port over the link
// Assumes: Shortened timeout, ready and quarter counts
// Notes:   Second link hand-driven to hold the clock low
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TO = 2000;

  logic              sys_clk;
  logic              rst_n;
  logic              cmdValid;
  logic              cmdReady;
  ssi_pkg::ssi_cmd_e cmdKind;
  logic        [6:0] cmdAddr;
  logic        [7:0] cmdPtr;
  logic        [7:0] cmdData;
  logic              done;
  logic        [7:0] hRd;
  logic              ackErr;
  logic              addrEn;
  logic              addrSel;
  logic        [7:0] regPtr;
  logic              regValid;
  logic              wrStrobe;
  logic        [7:0] wrData;
  logic        [7:0] devRd;
  logic              busReady;
  logic              addrLocked;
  logic        [6:0] busAddr;
  logic        [7:0] mem [256];
  logic        [7:0] wrCnt;
  logic              s;
  int                mismatches;
  int                compares;

  ssi_link_if link ();
  ssi_link_if link2 ();

  assign regValid = regPtr < 8'h80;
  assign devRd    = mem[regPtr];

  ssi_host #(.QTR_CYC(8)) u_ssi_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind),
    .cmdAddr(cmdAddr), .cmdPtr(cmdPtr), .cmdData(cmdData),
    .done(done), .rdData(hRd), .ackErr(ackErr));

  ssi_device #(.TIMEOUT_CYC(TO), .READY_CYC(50)) u_ssi_device (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .addrStrapEnable(addrEn), .addrSelect(addrSel),
    .regPtr(regPtr), .regValid(regValid), .wrStrobe(wrStrobe),
    .wrData(wrData), .rdData(devRd), .busReady(busReady),
    .addrLocked(addrLocked), .busAddr(busAddr));

  ssi_device #(.TIMEOUT_CYC(TO), .READY_CYC(50)) u_ssi_device_b (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link2),
    .addrStrapEnable(addrEn), .addrSelect(addrSel), .regPtr(),
    .regValid(1'b1), .wrStrobe(), .wrData(), .rdData(devRd),
    .busReady(), .addrLocked(), .busAddr());

  ssi_link_chk u_ssi_link_chk (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .hostSclOut(link.hostSclOut), .hostSclOe(link.hostSclOe),
    .hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe),
    .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe),
    .sclLevel(link.sclLevel), .sdaLevel(link.sdaLevel));

  always @(posedge sys_clk) begin
    if (wrStrobe) begin
      mem[regPtr] <= wrData;
      wrCnt       <= wrCnt + 8'h01;
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmd(input ssi_pkg::ssi_cmd_e k, input logic [6:0] a,
                     input logic [7:0] p, input logic [7:0] d);
    int n;
    cmdKind  = k;
    cmdAddr  = a;
    cmdPtr   = p;
    cmdData  = d;
    cmdValid = 1'b1;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      end_of_test();
    end
    chk({7'h00, cmdReady}, 8'h01);
  endtask

  // Hand-driven second link, one quarter of 40 ns
  task automatic px(input logic c, input logic d);
    link2.hostSclOe = c;
    link2.hostSdaOe = d;
    repeat (4) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdKind = ssi_pkg::CMD_WRITE;
    cmdAddr = 7'h00;
    cmdPtr = 8'h00;
    cmdData = 8'h00;
    addrEn = 1'b0;
    addrSel = 1'b1;
    wrCnt = 8'h00;
    mismatches = 0;
    compares = 0;
    link2.hostSclOut = 1'b0;
    link2.hostSdaOut = 1'b0;
    link2.hostSclOe = 1'b0;
    link2.hostSdaOe = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    cmd(ssi_pkg::CMD_WRITE, 7'h2d, 8'h05, 8'h11);
    chk({7'h00, ackErr}, 8'h01);
    chk({7'h00, busReady}, 8'h01);
    chk({7'h00, addrLocked}, 8'h00);
    cmd(ssi_pkg::CMD_WRITE, 7'h2d, 8'h05, 8'ha5);
    chk({7'h00, ackErr}, 8'h00);
    chk({1'b0, busAddr}, 8'h2d);
    chk({7'h00, addrLocked}, 8'h01);
    chk(regPtr, 8'h05);
    chk(wrData, 8'ha5);
    chk(wrCnt, 8'h01);
    addrEn = 1'b1;
    cmd(ssi_pkg::CMD_SETPTR, 7'h2e, 8'h06, 8'h00);
    chk({7'h00, ackErr}, 8'h01);
    cmd(ssi_pkg::CMD_SETPTR, 7'h2d, 8'h06, 8'h00);
    cmd(ssi_pkg::CMD_READ, 7'h2d, 8'h00, 8'h00);
    chk(hRd, 8'h3a);
    mem[6] = 8'h77;
    cmd(ssi_pkg::CMD_READ, 7'h2d, 8'h00, 8'h00);
    chk(hRd, 8'h77);
    cmd(ssi_pkg::CMD_PREAD, 7'h2d, 8'h05, 8'h00);
    chk(hRd, 8'ha5);
    chk(wrCnt, 8'h01);
    cmd(ssi_pkg::CMD_WRITE, 7'h2d, 8'h90, 8'h5a);
    chk(wrCnt, 8'h01);
    cmd(ssi_pkg::CMD_READ, 7'h2d, 8'h00, 8'h00);
    chk(hRd, 8'hff);
    // Address 2Eh write on the second link, then clock held low
    s = 1'b1;
    px(1'b0, s);
    for (int i = 7; i >= 0; i--) begin
      px(1'b1, s);
      s = !(8'h5c >> i & 8'h01);
      px(1'b1, s);
      px(1'b0, s);
      px(1'b0, s);
    end
    px(1'b1, s);
    px(1'b1, 1'b0);
    chk({7'h00, link2.devSdaOe}, 8'h01);
    repeat (TO - 100) @(negedge sys_clk);
    chk({7'h00, link2.devSdaOe}, 8'h01);
    repeat (200) @(negedge sys_clk);
    chk({7'h00, link2.devSdaOe}, 8'h00);
    px(1'b0, 1'b0);
    end_of_test();
  end
endmodule
